/* core/ftilc_link_ctrl.sv */
// Purpose: Lamps, relay, button, parameter mode, parameter store and byte routing.
// Assumes: All inputs synchronous to mclk; button input is already debounced.
// Notes: nrst stands for power-up; the parameter store is not cleared by soft resets.
`timescale 1ns/10ps
module ftilc_link_ctrl #(
  parameter int BLINK_CYCLES = ftilc_pkg::BLINK_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic button_pressed,
  input wire logic supply_ok,
  input wire logic bus_in_service,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic irq,
  input wire ftilc_pkg::ftilc_byte_type fibre_port_one_rx,
  input wire ftilc_pkg::ftilc_byte_type fibre_port_two_rx,
  output ftilc_pkg::ftilc_byte_type fibre_port_one_tx,
  output ftilc_pkg::ftilc_byte_type fibre_port_two_tx,
  input wire logic [1:0] bearer_ready,
  input wire ftilc_pkg::ftilc_byte_type bearer_one_rx,
  input wire ftilc_pkg::ftilc_byte_type bearer_two_rx,
  output ftilc_pkg::ftilc_byte_type bearer_one_tx,
  output ftilc_pkg::ftilc_byte_type bearer_two_tx,
  input wire logic [1:0] incoming_call,
  input wire logic [1:0] call_connected,
  output logic [1:0] dial_request,
  output logic [1:0] accept_call,
  output logic [2:0] baud_code,
  output logic alarm_relay,
  output logic led_fault,
  output logic led_fibre_one,
  output logic led_fibre_two
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] param_reg [0:255];  // Parameter image, addressed by host offset.
  logic cfg_req_reg;              // Host asked for parameter mode.
  logic param_mode_reg;           // Parameter mode active.
  logic restart_reg;              // One cycle restart after the exit command.
  logic [3:0] irq_stat_reg;       // Sticky events.
  logic [3:0] irq_mask_reg;       // Event enables.
  logic [3:0] irq_event;          // Events of this cycle.
  logic bus_seen_reg;             // Previous bus state, for the loss edge.
  logic soft_reset;               // Logic reset from the button or restart.
  logic [1:0] chan_enable;        // Channels the protocol lets carry data.
  logic [1:0] chan_ok;            // Channel may forward now.
  logic [1:0] fwd_up;             // Fibre byte forwarded to channel this cycle.
  logic [31:0] blink_cnt_reg [0:1]; // Activity hold counters.
  logic [1:0] blink_phase_reg;    // Lamp on/off phase while active.
  logic cmd_wr;                   // Write to the command offset.
  ftilc_pkg::ftilc_proto_type proto;

  // Parameter window test used by both the write and the read paths.
  function automatic logic is_param(input logic [7:0] a);
    is_param = (a >= ftilc_pkg::PARAM_BASE);
  endfunction

  // Rate code check: only codes inside the fibre rate range are stored.
  function automatic logic baud_legal(input logic [7:0] c);
    baud_legal = (c >= ftilc_pkg::BAUD_MIN_CODE) && (c <= ftilc_pkg::BAUD_MAX_CODE);
  endfunction

  assign cmd_wr = host_wr && (host_addr == ftilc_pkg::CMD_OFS);

  // Held button and the restart pulse both reset the operating logic.
  assign soft_reset = button_pressed | restart_reg;

  // ----------------------------------------
  // Parameter mode
  // ----------------------------------------

  // A configuration request waits for the button; the press then enters the mode.
  // The exit command clears both and triggers one restart cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_req_reg <= 1'b0;
      param_mode_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (cmd_wr && host_wdata == ftilc_pkg::CMD_RESTART) begin
        cfg_req_reg <= 1'b0;
        param_mode_reg <= 1'b0;
        restart_reg <= 1'b1;
      end else if (cmd_wr && host_wdata == ftilc_pkg::CMD_CFG_REQ) begin
        cfg_req_reg <= 1'b1;
      end else if (cfg_req_reg && button_pressed) begin
        // The press is the operator's confirmation; the status bit is the acknowledge.
        param_mode_reg <= 1'b1;
        cfg_req_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Parameter store
  // ----------------------------------------

  // Only nrst loads factory values; button and restart leave the image alone,
  // which is what lets downloaded values outlive a device reset.
  // Downloads are taken only in parameter mode, so a stray write in service
  // cannot change routing under live traffic.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 256; i++) begin
        if (i >= 32 && i < 64) begin
          param_reg[i] <= ftilc_pkg::FILL_RESET; // Numbers unset.
        end else begin
          param_reg[i] <= ftilc_pkg::BLANK_RESET; // Name and comment empty.
        end
      end
      param_reg[ftilc_pkg::ROLE_OFS] <= ftilc_pkg::ROLE_RESET; // Answer every call.
      param_reg[ftilc_pkg::PROTO_OFS] <= 8'(ftilc_pkg::PROTO_DIALLED);
      param_reg[ftilc_pkg::BAUD_OFS] <= ftilc_pkg::BAUD_RESET;
    end else if (host_wr && param_mode_reg && is_param(host_addr)) begin
      if (host_addr == ftilc_pkg::BAUD_OFS) begin
        if (baud_legal(host_wdata)) begin
          param_reg[host_addr] <= host_wdata; // Out-of-range rates are dropped.
        end
      end else if (host_addr >= ftilc_pkg::NAME_OFS + 8'(ftilc_pkg::NAME_LEN) &&
                   host_addr < ftilc_pkg::OWN1_OFS) begin
        // Bytes past the 13th name character are not kept.
      end else begin
        param_reg[host_addr] <= host_wdata;
      end
    end
  end

  // ----------------------------------------
  // Host read port
  // ----------------------------------------

  // Read data appear the cycle after the strobe. Parameters upload only in
  // parameter mode; outside it and at unmapped offsets below PARAM_BASE the port reads zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      if (host_addr == ftilc_pkg::STATUS_OFS) begin
        host_rdata <= {3'b000, bus_in_service, alarm_relay, restart_reg, param_mode_reg, cfg_req_reg};
      end else if (host_addr == ftilc_pkg::IRQ_STAT_OFS) begin
        host_rdata <= {4'h0, irq_stat_reg};
      end else if (host_addr == ftilc_pkg::IRQ_MASK_OFS) begin
        host_rdata <= {4'h0, irq_mask_reg};
      end else if (param_mode_reg && is_param(host_addr)) begin
        host_rdata <= param_reg[host_addr];
      end else begin
        host_rdata <= 8'h00;
      end
    end else begin
      host_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------

  assign irq_event[ftilc_pkg::IRQ_RX1] = fwd_up[0];
  assign irq_event[ftilc_pkg::IRQ_RX2] = fwd_up[1];
  assign irq_event[ftilc_pkg::IRQ_PMODE] = cfg_req_reg && button_pressed && !cmd_wr;
  assign irq_event[ftilc_pkg::IRQ_BUSLOST] = bus_seen_reg && !bus_in_service;

  // Bus state history for the loss edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_seen_reg <= 1'b0;
    end else begin
      bus_seen_reg <= bus_in_service;
    end
  end

  // Sticky status; an event in the clearing cycle survives the clear.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= 4'h0;
    end else if (host_wr && host_addr == ftilc_pkg::IRQ_STAT_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~host_wdata[3:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  // Mask register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_reg <= 4'h0;
    end else if (host_wr && host_addr == ftilc_pkg::IRQ_MASK_OFS) begin
      irq_mask_reg <= host_wdata[3:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Protocol, roles and call control
  // ----------------------------------------

  assign proto = ftilc_pkg::ftilc_proto_type'(param_reg[ftilc_pkg::PROTO_OFS]);
  assign baud_code = param_reg[ftilc_pkg::BAUD_OFS][2:0];

  // Leased modes fix which channels carry data; the dialled mode needs a call.
  always_comb begin
    case (proto)
      ftilc_pkg::PROTO_DIALLED: chan_enable = call_connected;
      ftilc_pkg::PROTO_LEASED_B1: chan_enable = 2'b01;
      ftilc_pkg::PROTO_LEASED_B2: chan_enable = 2'b10;
      ftilc_pkg::PROTO_LEASED_BOTH: chan_enable = 2'b11;
      default: chan_enable = 2'b00;
    endcase
  end

  // A dialling connection keeps asking until the call stands; an answering one
  // only picks up. The far end is trusted to hold the opposite role, since a
  // pair of diallers would just keep meeting a busy line.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dial_request <= 2'b00;
      accept_call <= 2'b00;
    end else if (soft_reset || param_mode_reg || proto != ftilc_pkg::PROTO_DIALLED) begin
      dial_request <= 2'b00;
      accept_call <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        dial_request[i] <= param_reg[ftilc_pkg::ROLE_OFS][i] && !call_connected[i];
        accept_call[i] <= !param_reg[ftilc_pkg::ROLE_OFS][i] && incoming_call[i];
      end
    end
  end

  // ----------------------------------------
  // Byte forwarding
  // ----------------------------------------

  // Port one always pairs with the first channel, port two with the second.
  assign chan_ok = bearer_ready & chan_enable & {2{!param_mode_reg && !soft_reset}};
  assign fwd_up = {fibre_port_two_rx.valid, fibre_port_one_rx.valid} & chan_ok;

  // Registered copy in both directions.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bearer_one_tx <= '0;
      bearer_two_tx <= '0;
      fibre_port_one_tx <= '0;
      fibre_port_two_tx <= '0;
    end else begin
      bearer_one_tx <= '{valid: fwd_up[0], data: fibre_port_one_rx.data};
      bearer_two_tx <= '{valid: fwd_up[1], data: fibre_port_two_rx.data};
      fibre_port_one_tx <= '{valid: bearer_one_rx.valid && chan_ok[0], data: bearer_one_rx.data};
      fibre_port_two_tx <= '{valid: bearer_two_rx.valid && chan_ok[1], data: bearer_two_rx.data};
    end
  end

  // ----------------------------------------
  // Activity lamps
  // ----------------------------------------

  // A byte forwarded while no hold runs arms the count; the phase flips at arming and at expiry,
  // so a steady stream keeps the lamp lit but for one cycle per hold. Nothing from the far end feeds this.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_reg[0] <= 32'h0;
      blink_cnt_reg[1] <= 32'h0;
      blink_phase_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (blink_cnt_reg[i] != 32'h0) begin
          blink_cnt_reg[i] <= blink_cnt_reg[i] - 32'h1;
          if (blink_cnt_reg[i] == 32'h1) begin
            blink_phase_reg[i] <= !blink_phase_reg[i];
          end
        end else if (fwd_up[i]) begin
          blink_cnt_reg[i] <= 32'(BLINK_CYCLES);
          blink_phase_reg[i] <= !blink_phase_reg[i];
        end else begin
          blink_phase_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Relay and fault lamp
  // ----------------------------------------

  // The relay drops during any internal reset, including a held button.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alarm_relay <= 1'b0;
    end else begin
      alarm_relay <= supply_ok && !soft_reset && bus_in_service;
    end
  end

  // Lamps from flip-flops; a held button forces all three on as a lamp test.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      led_fault <= 1'b1;
      led_fibre_one <= 1'b0;
      led_fibre_two <= 1'b0;
    end else begin
      led_fault <= button_pressed || !(supply_ok && !restart_reg && bus_in_service);
      led_fibre_one <= button_pressed || blink_phase_reg[0];
      led_fibre_two <= button_pressed || blink_phase_reg[1];
    end
  end

endmodule // ftilc_link_ctrl

/* include/ftilc_pkg.sv */
// Purpose: Constants and types shared by the fibre to ISDN link control block.
// Assumes: One 200 MHz clock; host reaches the block over a plain byte port.
// Notes: Offsets are byte-port addresses; all parameters live in one byte array.
//
// How it works
// - Defaults answer all calls, B1/B2 to ports.
// - Fibre bit rate held between 300 and 19200.
// - Fault lamp dark only when relay energised.
// - Activity lamp blinks on forwarded received data.
// - Blinking shows local forwarding, no remote confirmation.
// - Push button resets the device logic.
// - Button held lights lamps, drops alarm relay.
// - Config request then button enters parameter mode.
// - Parameter mode accepts downloads and answers uploads.
// - Host reset command leaves mode and restarts.
// - Downloaded parameters kept across soft resets.
// - Name parameter holds up to 13 characters.
// - Per connection: own, partner number, role.
// - Originate role dials; answer role only accepts.
// - Protocol: dialled, leased B1, B2, or both.
// - Free comment text stored with parameters.
// - Relay needs supply, no reset, bus in service.
package ftilc_pkg;

  // ----------------------------------------
  // Host port map
  // ----------------------------------------
  localparam logic [7:0] CMD_OFS = 8'h00;      // Write: command code.
  localparam logic [7:0] STATUS_OFS = 8'h01;   // Read: block state.
  localparam logic [7:0] IRQ_STAT_OFS = 8'h02; // Sticky events, write one to clear.
  localparam logic [7:0] IRQ_MASK_OFS = 8'h03; // Interrupt enables.
  localparam logic [7:0] PARAM_BASE = 8'h10;   // First parameter byte.
  localparam logic [7:0] NAME_OFS = 8'h10;     // Device name, 13 bytes.
  localparam int NAME_LEN = 13;                // Longest name in characters.
  localparam logic [7:0] OWN1_OFS = 8'h20;     // Own number, connection one.
  localparam logic [7:0] PART1_OFS = 8'h28;    // Partner number, connection one.
  localparam logic [7:0] OWN2_OFS = 8'h30;     // Own number, connection two.
  localparam logic [7:0] PART2_OFS = 8'h38;    // Partner number, connection two.
  localparam logic [7:0] ROLE_OFS = 8'h40;     // Bit 0/1: connection dials.
  localparam logic [7:0] PROTO_OFS = 8'h41;    // Signalling protocol code.
  localparam logic [7:0] BAUD_OFS = 8'h42;     // Fibre bit rate code.
  localparam logic [7:0] COMMENT_OFS = 8'h80;  // Free comment text up to 0xff.

  // ----------------------------------------
  // Command codes and defaults
  // ----------------------------------------
  localparam logic [7:0] CMD_CFG_REQ = 8'h01;  // Ask for parameter mode.
  localparam logic [7:0] CMD_RESTART = 8'h02;  // Leave parameter mode and restart.
  localparam logic [7:0] ROLE_RESET = 8'h00;   // Both connections answer only.
  localparam logic [7:0] BAUD_RESET = 8'h06;   // 19200 baud.
  localparam logic [7:0] FILL_RESET = 8'h2d;   // Unused number digits read as a dash.
  localparam logic [7:0] BLANK_RESET = 8'h00;  // Name and comment start empty.
  localparam logic [7:0] BAUD_MIN_CODE = 8'h00; // 300 baud.
  localparam logic [7:0] BAUD_MAX_CODE = 8'h06; // 19200 baud, doubling per code.
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 19200;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;               // 200 MHz.
  localparam longint BLINK_TIME_PS = 64'd50000000000; // 50 ms lamp on time per hold.
  localparam int BLINK_CYCLES = int'(BLINK_TIME_PS / CLK_PERIOD_PS);

  // Interrupt bit positions.
  localparam int IRQ_RX1 = 0;
  localparam int IRQ_RX2 = 1;
  localparam int IRQ_PMODE = 2;
  localparam int IRQ_BUSLOST = 3;

  // Signalling protocol choices.
  typedef enum logic [7:0] {
    PROTO_DIALLED = 8'h00,
    PROTO_LEASED_B1 = 8'h01,
    PROTO_LEASED_B2 = 8'h02,
    PROTO_LEASED_BOTH = 8'h03
  } ftilc_proto_type;

  // One byte with its valid flag.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ftilc_byte_type;

endpackage

/* bench/ftilc_far_model.sv */
// Purpose: Remote converter model: rings, answers our dialling, raises channel ready.
// Assumes: Driven from mclk; the bench sets ring, lease and slow by NBA.
// Notes: A call stays up until power-up reset, since no scenario hangs up.
`timescale 1ns/10ps
module ftilc_far_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] ring,
  input wire logic [1:0] lease,
  input wire logic slow,
  input wire logic [1:0] dial_request,
  input wire logic [1:0] accept_call,
  output logic [1:0] incoming_call,
  output logic [1:0] call_connected,
  output logic [1:0] bearer_ready
);
  logic [1:0][2:0] wait_cnt; // Cycles that each request has waited.

  // Ringing stops once the call is up; a leased channel is ready at once.
  assign incoming_call = ring & ~call_connected;
  assign bearer_ready = call_connected | lease;

  // The far end always holds the opposite role, so a request is met, promptly or late.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      call_connected <= 2'b00;
      wait_cnt <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((dial_request[i] || accept_call[i]) && !call_connected[i]) begin
          wait_cnt[i] <= wait_cnt[i] + 3'h1;
          if (wait_cnt[i] >= (slow ? 3'h5 : 3'h0)) begin
            call_connected[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule // ftilc_far_model

/* bench/ftilc_link_ctrl_sva.sv */
// Purpose: Port-level checks of lamps, relay, host reads and forwarding.
// Assumes: One clock domain, nrst low resets all.
// Notes: Restart and mode flags are internal, so only their port effects are seen.
`timescale 1ns/10ps
module ftilc_link_ctrl_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic button_pressed,
  input wire logic supply_ok,
  input wire logic bus_in_service,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata,
  input wire ftilc_pkg::ftilc_byte_type fibre_port_one_rx,
  input wire ftilc_pkg::ftilc_byte_type bearer_one_tx,
  input wire logic [1:0] call_connected,
  input wire logic [1:0] dial_request,
  input wire logic [1:0] accept_call,
  input wire logic [2:0] baud_code,
  input wire logic alarm_relay,
  input wire logic led_fault,
  input wire logic led_fibre_one,
  input wire logic led_fibre_two
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_RELAY_OFF: assert property ((button_pressed || !supply_ok || !bus_in_service) |=> !alarm_relay)
    else $error("relay energised while not allowed");
  AST_FAULT_MIRROR: assert property (led_fault != alarm_relay)
    else $error("fault lamp does not mirror relay");
  AST_FAULT_DARK: assert property (!led_fault |-> $past(supply_ok && bus_in_service && !button_pressed))
    else $error("fault lamp dark without cause");
  AST_LAMP_TEST: assert property (button_pressed |=> led_fault && led_fibre_one && led_fibre_two)
    else $error("lamp test missing");
  AST_RD_ZERO: assert property (!host_rd |=> host_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_FWD_DATA: assert property (bearer_one_tx.valid |-> $past(fibre_port_one_rx.valid)
    && bearer_one_tx.data == $past(fibre_port_one_rx.data))
    else $error("channel byte not from fibre");
  AST_SOFT_RESET: assert property (button_pressed |=> !bearer_one_tx.valid && dial_request == 2'b00)
    else $error("activity during button reset");
  AST_BAUD: assert property (baud_code <= 3'h6)
    else $error("bit rate code out of range");
  AST_ROLE: assert property (dial_request[0] |-> !accept_call[0] && $past(!call_connected[0]))
    else $error("dial and answer mixed");
endmodule // ftilc_link_ctrl_sva
bind ftilc_link_ctrl ftilc_link_ctrl_sva chk_u (.mclk(mclk), .nrst(nrst), .button_pressed(button_pressed),
  .supply_ok(supply_ok), .bus_in_service(bus_in_service), .host_rd(host_rd), .host_rdata(host_rdata),
  .fibre_port_one_rx(fibre_port_one_rx), .bearer_one_tx(bearer_one_tx), .call_connected(call_connected),
  .dial_request(dial_request), .accept_call(accept_call), .baud_code(baud_code), .alarm_relay(alarm_relay),
  .led_fault(led_fault), .led_fibre_one(led_fibre_one), .led_fibre_two(led_fibre_two));

/* bench/ftilc_link_ctrl_bench.sv */
// Purpose: Self-checking bench for the link control block.
// Assumes: Tasks enter just after a settled point and drive by NBA at rising edges.
// Notes: Blink time shortened to 8 cycles so lamp timing fits a short run.
`timescale 1ns/10ps
module ftilc_link_ctrl_bench;
  logic mclk, nrst, button_pressed, supply_ok, bus_in_service, host_wr, host_rd, irq, slow, seen;
  logic alarm_relay, led_fault, led_fibre_one, led_fibre_two;
  logic [7:0] host_addr, host_wdata, host_rdata, rd_val;
  logic [1:0] bearer_ready, incoming_call, call_connected, dial_request, accept_call, ring, lease;
  logic [2:0] baud_code;
  ftilc_pkg::ftilc_byte_type src [4]; // Fibre one, fibre two, channel one, channel two.
  ftilc_pkg::ftilc_byte_type fibre_port_one_tx, fibre_port_two_tx, bearer_one_tx, bearer_two_tx;
  int error_cnt, check_count;

  ftilc_link_ctrl #(.BLINK_CYCLES(8)) dut_u (.mclk(mclk), .nrst(nrst), .button_pressed(button_pressed),
    .supply_ok(supply_ok), .bus_in_service(bus_in_service), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .irq(irq), .fibre_port_one_rx(src[0]),
    .fibre_port_two_rx(src[1]), .fibre_port_one_tx(fibre_port_one_tx), .fibre_port_two_tx(fibre_port_two_tx),
    .bearer_ready(bearer_ready), .bearer_one_rx(src[2]), .bearer_two_rx(src[3]), .bearer_one_tx(bearer_one_tx),
    .bearer_two_tx(bearer_two_tx), .incoming_call(incoming_call), .call_connected(call_connected),
    .dial_request(dial_request), .accept_call(accept_call), .baud_code(baud_code), .alarm_relay(alarm_relay),
    .led_fault(led_fault), .led_fibre_one(led_fibre_one), .led_fibre_two(led_fibre_two));
  ftilc_far_model far_u (.mclk(mclk), .nrst(nrst), .ring(ring), .lease(lease), .slow(slow),
    .dial_request(dial_request), .accept_call(accept_call), .incoming_call(incoming_call),
    .call_connected(call_connected), .bearer_ready(bearer_ready));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host write: strobe one cycle, then let the taking edge settle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
    #1;
  endtask
  // Host read: data stands only in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask
  // One byte; idle data shows the inverse so a stale value cannot pass.
  task automatic send(input int p, input logic [7:0] d);
    @(posedge mclk);
    src[p] <= {1'b1, d};
    @(posedge mclk);
    src[p] <= {1'b0, ~d};
    #1;
  endtask
  task automatic press(input int n);
    @(posedge mclk);
    button_pressed <= 1'b1;
    repeat (n) @(posedge mclk);
    button_pressed <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic enter_pm;
    wr(ftilc_pkg::CMD_OFS, ftilc_pkg::CMD_CFG_REQ);
    press(3);
  endtask
  task automatic leave_pm;
    wr(ftilc_pkg::CMD_OFS, ftilc_pkg::CMD_RESTART);
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // A hang is far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst, button_pressed, host_wr, host_rd, slow, ring, lease} = '0;
    {supply_ok, bus_in_service, host_addr, host_wdata} = {2'b11, 16'h0000};
    for (int k = 0; k < 4; k++) src[k] = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    chk(9'({alarm_relay, led_fault}), 9'h1);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(9'({alarm_relay, led_fault}), 9'h2);
    // Supply, then bus, drops; relay must release and the fault lamp light.
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      {supply_ok, bus_in_service} <= k ? 2'b10 : 2'b01;
      repeat (2) @(posedge mclk);
      #1;
      chk(9'({alarm_relay, led_fault}), 9'h1);
    end
    @(posedge mclk);
    {supply_ok, bus_in_service, button_pressed} <= 3'b111;
    repeat (2) @(posedge mclk);
    #1;
    chk(9'({alarm_relay, led_fault, led_fibre_one, led_fibre_two}), 9'h7);
    press(1);
    chk(9'(alarm_relay), 9'h1);
    $display("test lamps done");
    // Factory roles answer both calls and route B1/B2 to ports one/two.
    @(posedge mclk);
    {ring, slow} <= 3'b111;
    repeat (2) @(posedge mclk);
    #1;
    chk(9'({dial_request, accept_call}), 9'h3);
    for (int k = 0; k < 20 && call_connected !== 2'b11; k++) @(posedge mclk);
    #1;
    chk(9'(call_connected), 9'h3);
    send(0, 8'h5a);
    chk(bearer_one_tx, 9'h15a);
    chk(9'(bearer_two_tx.valid), 9'h0);
    seen = 1'b0;
    repeat (3) begin
      @(posedge mclk);
      #1;
      seen |= led_fibre_one;
    end
    chk(9'(seen), 9'h1);
    repeat (40) @(posedge mclk);
    #1;
    chk(9'(led_fibre_one), 9'h0);
    send(1, 8'ha5);
    chk(bearer_two_tx, 9'h1a5);
    send(2, 8'hc3);
    chk(fibre_port_one_tx, 9'h1c3);
    send(3, 8'h3c);
    chk(fibre_port_two_tx, 9'h13c);
    chk(9'(irq), 9'h0);
    rd(ftilc_pkg::IRQ_STAT_OFS, rd_val);
    chk(9'(rd_val & 8'h03), 9'h3);
    wr(ftilc_pkg::IRQ_MASK_OFS, 8'h01);
    chk(9'(irq), 9'h1);
    wr(ftilc_pkg::IRQ_STAT_OFS, 8'h01);
    chk(9'(irq), 9'h0);
    rd(8'h05, rd_val);
    chk(9'(rd_val), 9'h0);
    wr(ftilc_pkg::BAUD_OFS, 8'h02);
    chk(9'(baud_code), 9'h6);
    $display("test forwarding done");
    // Parameter mode: request, button, download, restart, upload.
    wr(ftilc_pkg::CMD_OFS, ftilc_pkg::CMD_CFG_REQ);
    rd(ftilc_pkg::STATUS_OFS, rd_val);
    chk(9'(rd_val[0]), 9'h1);
    press(3);
    rd(ftilc_pkg::STATUS_OFS, rd_val);
    chk(9'(rd_val[1]), 9'h1);
    rd(ftilc_pkg::IRQ_STAT_OFS, rd_val);
    chk(9'(rd_val[2]), 9'h1);
    send(0, 8'h11);
    chk(9'(bearer_one_tx.valid), 9'h0);
    for (int k = 0; k < 16; k++) wr(ftilc_pkg::NAME_OFS + 8'(k), 8'h41 + 8'(k));
    wr(ftilc_pkg::COMMENT_OFS + 8'h7f, 8'h77);
    wr(ftilc_pkg::OWN1_OFS, 8'h31);
    wr(ftilc_pkg::BAUD_OFS, 8'h07);
    chk(9'(baud_code), 9'h6);
    wr(ftilc_pkg::BAUD_OFS, 8'h00);
    chk(9'(baud_code), 9'h0);
    leave_pm;
    rd(ftilc_pkg::STATUS_OFS, rd_val);
    chk(9'(rd_val[1]), 9'h0);
    enter_pm;
    for (int k = 0; k < 16; k++) begin
      rd(ftilc_pkg::NAME_OFS + 8'(k), rd_val);
      chk(9'(rd_val), 9'(k < ftilc_pkg::NAME_LEN ? 8'h41 + 8'(k) : 8'h00));
    end
    rd(ftilc_pkg::COMMENT_OFS + 8'h7f, rd_val);
    chk(9'(rd_val), 9'h77);
    rd(ftilc_pkg::OWN1_OFS, rd_val);
    chk(9'(rd_val), 9'h31);
    rd(ftilc_pkg::PART1_OFS, rd_val);
    chk(9'(rd_val), 9'(ftilc_pkg::FILL_RESET));
    $display("test parameter mode done");
    // Power-up again, then every signalling protocol with connection one dialling.
    @(posedge mclk);
    {nrst, ring, lease} <= 5'b00011;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(9'({baud_code, accept_call}), 9'h18);
    for (int p = 0; p < 4; p++) begin
      enter_pm;
      wr(ftilc_pkg::ROLE_OFS, 8'h01);
      wr(ftilc_pkg::PROTO_OFS, 8'(p));
      leave_pm;
      chk(9'(dial_request), 9'(p == 0));
      send(1, 8'h60 + 8'(p));
      chk(9'(bearer_two_tx.valid), 9'(p >= 2));
    end
    $display("test protocols done");
    results;
  end
endmodule // ftilc_link_ctrl_bench
